/* logic/tcs_pkg.sv */
/*
 * tcs_pkg: constants shared by the transmit collision statistics block.
 * Assumes an APB slave with 32-bit data; each 16-bit half register takes one aligned word.
 */
package tcs_pkg;
	// printed register numbers are indexes; byte address is four times the index
	localparam logic [7:0] IDX_SINGLE_COL = 8'h10;
	localparam logic [7:0] IDX_EXCESS_COL = 8'h12;
	localparam logic [7:0] IDX_MULTI_COL = 8'h14;
	localparam logic [7:0] IDX_LATE_COL = 8'h17;
	localparam logic [7:0] IDX_TOTAL_COL = 8'h19;
	localparam logic [7:0] IDX_DEFER = 8'h1b;
	localparam logic [7:0] IDX_NO_CARRIER = 8'h1d;
	// control register holding the retry threshold and enables
	localparam logic [7:0] IDX_CTRL = 8'h20;
	localparam int NUM_CNT = 7;
	localparam int HALF_W = 16;
	localparam logic [7:0] EXCESS_LIMIT = 8'h10;
	localparam logic [7:0] THRESH_RESET = 8'h0f;
	localparam int CTRL_THRESH_LSB = 0;
	localparam int CTRL_TX_EN_BIT = 8;
	localparam int CTRL_HALF_DUPLEX_BIT = 9;
	localparam int SLOT_BIT_TIMES = 512;
	localparam logic [31:0] CNT_RESET = 32'h0000_0000;
	typedef enum logic [2:0] {
		TCS_SINGLE, TCS_EXCESS, TCS_MULTI, TCS_LATE, TCS_TOTAL, TCS_DEFER, TCS_NOCRS
	} tcs_cnt_t;
endpackage

/* logic/tcs_counters.sv */
/*
 * tcs_counters: seven 32-bit transmit statistics counters read over APB as 16-bit halves,
 * plus one control word that holds the retry threshold, transmit enable and half duplex.
 * The counters watch the transmit handshake of the attached LAN controller: a rise of
 * tx_en opens an attempt, tx_collision and tx_success are one-cycle pulses, and the
 * defer inputs are levels that stand while a pending frame is held back.
 * Retries of one frame share one collision tally; a new frame starts only when the
 * previous one has ended in success or in the excessive close.
 * The slave answers every access with one wait state, so ready, error and read data
 * all come from flops and nothing reaches an output through logic.
 * Assumes every input, bus and transmit side alike, is synchronous to pclk and settled
 * well before its rising edge.
 * Assumes presetn is asynchronous and active low; it clears every counter and returns
 * the control word to its reset value.
 * Assumes SLOT_CYCLES is the slot time expressed in pclk cycles for the running link
 * speed; it must fit the 16-bit slot timer.
 * Assumes software reads the high half first and accepts that the two halves are not
 * latched together: a counter that moves between the two reads can show a torn value.
 * Assumes a frame that stops without success below the excessive limit stays open, and
 * that its next rise of tx_en is then taken as a retry of that frame.
 * Assumes the no-carrier count is ignored by software while the link runs full duplex.
 */
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Each counter is 32 bits read as two halves, the higher index giving the low half and the lower index the high half.
// - Single-collision counts successful frames that saw exactly one collision.
// - Collision counters advance only with transmit enabled in half duplex and hold in full duplex.
// - Excessive-collision counts a frame once it reaches 16 collisions, provided the threshold is 16 or more.
// - With the retry threshold below 16 the excessive-collision counter never advances.
// - Multiple-collision counts successful frames with more than one but fewer than 16 collisions.
// - Late-collision counts a frame once when a collision comes after one slot time from the rise of its current attempt.
// - Total-collision adds every collision, clear or secured traffic alike.
// - Defer counts each time a pending frame cannot go at once for busy medium, gap, deferral, pause or link down.
// - Defer advances only with transmit enabled, in either duplex.
// - Defer ignores hold-off of streaming back-to-back frames caused only by the gap timer.
// - No-carrier counts successful frames without carrier within one slot time of transmit enable rising.
// - Carrier should be present through every transmission, its absence showing a link fault.
// - No-carrier advances only with transmit enabled and is meaningful only in half duplex.
// - Late-collision counts affected frames, not late collision events.
module tcs_counters #(
	parameter int SLOT_CYCLES = tcs_pkg::SLOT_BIT_TIMES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic tx_en,
	input wire logic crs,
	input wire logic tx_collision,
	input wire logic tx_success,
	input wire logic tx_secure,
	input wire logic defer_busy,
	input wire logic defer_ipg,
	input wire logic defer_hdx,
	input wire logic defer_xoff,
	input wire logic defer_link_down,
	input wire logic tx_streaming
);
	// refuse slot lengths that the 16-bit slot timer cannot hold
	if (SLOT_CYCLES < 1 || SLOT_CYCLES > 65535) begin : g_bad_slot
		$error("slot length out of range");
	end

	// counters and the control word
	logic [31:0] cnt_q [tcs_pkg::NUM_CNT];
	logic [7:0] thresh_q;
	logic tx_enabled_q;
	logic half_duplex_q;
	// state of the frame in flight
	logic tx_en_prev_q;
	logic [15:0] slot_cnt_q;
	logic in_frame_q;
	logic [7:0] col_cnt_q;
	logic late_seen_q;
	logic crs_seen_q;
	logic excess_done_q;
	logic defer_prev_q;
	// decisions and bus decode
	logic [tcs_pkg::NUM_CNT-1:0] inc;
	logic frame_start;
	logic new_frame;
	logic slot_over;
	logic defer_medium;
	logic defer_pause;
	logic defer_gap;
	logic defer_now;
	logic [7:0] col_next;
	logic [7:0] idx;
	logic access;
	logic ctrl_wr;
	logic mapped;

	// index of a word address; the upper address bits and low byte lanes are ignored
	function automatic logic [7:0] word_index(input logic [11:0] a);
		return a[9:2];
	endfunction

	// counter readout for one half register
	function automatic logic [15:0] half_of(input logic [31:0] v, input logic upper);
		return upper ? v[31:16] : v[15:0];
	endfunction

	// true for the fourteen half registers of the seven counters
	function automatic logic is_counter_index(input logic [7:0] i);
		logic hit;
		hit = 1'b0;
		unique case (i)
			tcs_pkg::IDX_SINGLE_COL, tcs_pkg::IDX_SINGLE_COL + 8'h01: hit = 1'b1;
			tcs_pkg::IDX_EXCESS_COL, tcs_pkg::IDX_EXCESS_COL + 8'h01: hit = 1'b1;
			tcs_pkg::IDX_MULTI_COL, tcs_pkg::IDX_MULTI_COL + 8'h01: hit = 1'b1;
			tcs_pkg::IDX_LATE_COL, tcs_pkg::IDX_LATE_COL + 8'h01: hit = 1'b1;
			tcs_pkg::IDX_TOTAL_COL, tcs_pkg::IDX_TOTAL_COL + 8'h01: hit = 1'b1;
			tcs_pkg::IDX_DEFER, tcs_pkg::IDX_DEFER + 8'h01: hit = 1'b1;
			tcs_pkg::IDX_NO_CARRIER, tcs_pkg::IDX_NO_CARRIER + 8'h01: hit = 1'b1;
			default: hit = 1'b0;
		endcase
		return hit;
	endfunction

	// readback of one index: a counter gives one half in the low bits, the control word its fields
	function automatic logic [31:0] read_word(input logic [7:0] i);
		logic [31:0] w;
		w = 32'h0000_0000;
		unique case (i)
			tcs_pkg::IDX_SINGLE_COL: w = {16'h0000, half_of(cnt_q[tcs_pkg::TCS_SINGLE], 1'b1)};
			tcs_pkg::IDX_SINGLE_COL + 8'h01: w = {16'h0000, half_of(cnt_q[tcs_pkg::TCS_SINGLE], 1'b0)};
			tcs_pkg::IDX_EXCESS_COL: w = {16'h0000, half_of(cnt_q[tcs_pkg::TCS_EXCESS], 1'b1)};
			tcs_pkg::IDX_EXCESS_COL + 8'h01: w = {16'h0000, half_of(cnt_q[tcs_pkg::TCS_EXCESS], 1'b0)};
			tcs_pkg::IDX_MULTI_COL: w = {16'h0000, half_of(cnt_q[tcs_pkg::TCS_MULTI], 1'b1)};
			tcs_pkg::IDX_MULTI_COL + 8'h01: w = {16'h0000, half_of(cnt_q[tcs_pkg::TCS_MULTI], 1'b0)};
			tcs_pkg::IDX_LATE_COL: w = {16'h0000, half_of(cnt_q[tcs_pkg::TCS_LATE], 1'b1)};
			tcs_pkg::IDX_LATE_COL + 8'h01: w = {16'h0000, half_of(cnt_q[tcs_pkg::TCS_LATE], 1'b0)};
			tcs_pkg::IDX_TOTAL_COL: w = {16'h0000, half_of(cnt_q[tcs_pkg::TCS_TOTAL], 1'b1)};
			tcs_pkg::IDX_TOTAL_COL + 8'h01: w = {16'h0000, half_of(cnt_q[tcs_pkg::TCS_TOTAL], 1'b0)};
			tcs_pkg::IDX_DEFER: w = {16'h0000, half_of(cnt_q[tcs_pkg::TCS_DEFER], 1'b1)};
			tcs_pkg::IDX_DEFER + 8'h01: w = {16'h0000, half_of(cnt_q[tcs_pkg::TCS_DEFER], 1'b0)};
			tcs_pkg::IDX_NO_CARRIER: w = {16'h0000, half_of(cnt_q[tcs_pkg::TCS_NOCRS], 1'b1)};
			tcs_pkg::IDX_NO_CARRIER + 8'h01: w = {16'h0000, half_of(cnt_q[tcs_pkg::TCS_NOCRS], 1'b0)};
			tcs_pkg::IDX_CTRL: w = {22'h000000, half_duplex_q, tx_enabled_q, thresh_q};
			default: w = 32'h0000_0000;
		endcase
		return w;
	endfunction

	// a rise of transmit enable opens a frame or a retry
	assign frame_start = tx_en && !tx_en_prev_q;
	// a rise with no frame open starts a fresh tally; a rise inside one is a retry
	assign new_frame = frame_start && !in_frame_q;
	// slot elapsed since the last rise; the timer stops there so it cannot wrap
	assign slot_over = slot_cnt_q >= 16'(SLOT_CYCLES);
	assign col_next = tx_collision ? col_cnt_q + 8'h01 : col_cnt_q;
	// medium held by another station, or a half-duplex deferral
	assign defer_medium = defer_busy || defer_hdx;
	// pause frame received, or no link
	assign defer_pause = defer_xoff || defer_link_down;
	// gap-only hold-off of a streaming burst is not a defer event
	assign defer_gap = defer_ipg && !tx_streaming;
	assign defer_now = defer_medium || defer_pause || defer_gap;
	// bus decode
	assign idx = word_index(paddr);
	assign access = psel && penable;
	// the control word is written at the access edge
	assign ctrl_wr = access && pwrite && idx == tcs_pkg::IDX_CTRL;
	// counter halves and the control word; everything else answers with an error
	assign mapped = is_counter_index(idx) || idx == tcs_pkg::IDX_CTRL;

	// transmit enable of the last cycle, for the rise that opens an attempt
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_en_prev_q <= 1'b0;
		end else begin
			tx_en_prev_q <= tx_en;
		end
	end

	// defer condition of the last cycle; a cause that stands for long counts once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			defer_prev_q <= 1'b0;
		end else begin
			defer_prev_q <= defer_now;
		end
	end

	// frame open from its first rise until success or the excessive close
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in_frame_q <= 1'b0;
		end else if (new_frame) begin
			in_frame_q <= 1'b1;
		end else if (!frame_start && (tx_success || inc[tcs_pkg::TCS_EXCESS])) begin
			in_frame_q <= 1'b0;
		end
	end

	// slot timer restarts on every rise and stops once the slot is over
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slot_cnt_q <= 16'h0000;
		end else if (frame_start) begin
			slot_cnt_q <= 16'h0000;
		end else if (!slot_over) begin
			slot_cnt_q <= slot_cnt_q + 16'h0001;
		end
	end

	// retries keep the collision tally; only a new frame clears it
	// it saturates, except that a collision in the cycle of a retry rise at 255 folds it back to 0
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			col_cnt_q <= 8'h00;
		end else if (new_frame) begin
			col_cnt_q <= 8'h00;
		end else if (frame_start || col_cnt_q != 8'hff) begin
			col_cnt_q <= col_next;
		end
	end

	// one late hit marks the frame so later ones are not counted again
	// the mark survives retries, as the count is of frames, not of hits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			late_seen_q <= 1'b0;
		end else if (new_frame) begin
			late_seen_q <= 1'b0;
		end else if (!frame_start && tx_collision && slot_over) begin
			late_seen_q <= 1'b1;
		end
	end

	// carrier seen at the rise or anywhere inside the slot that follows it
	// every retry gets its own window, measured from its own rise
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			crs_seen_q <= 1'b0;
		end else if (frame_start) begin
			crs_seen_q <= crs;
		end else if (crs && !slot_over) begin
			crs_seen_q <= 1'b1;
		end
	end

	// excessive close counted once per frame
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			excess_done_q <= 1'b0;
		end else if (new_frame) begin
			excess_done_q <= 1'b0;
		end else if (!frame_start && inc[tcs_pkg::TCS_EXCESS]) begin
			excess_done_q <= 1'b1;
		end
	end

	// increment decisions for each counter
	always_comb begin
		inc = '0;
		if (tx_enabled_q && half_duplex_q) begin
			// exactly one collision before success
			inc[tcs_pkg::TCS_SINGLE] = tx_success && col_next == 8'h01;
			// more than one, fewer than the excessive limit
			inc[tcs_pkg::TCS_MULTI] = tx_success && col_next > 8'h01 &&
				col_next < tcs_pkg::EXCESS_LIMIT;
			// a threshold below the limit never lets a frame reach it
			inc[tcs_pkg::TCS_EXCESS] = in_frame_q && !excess_done_q &&
				col_next >= tcs_pkg::EXCESS_LIMIT &&
				thresh_q >= tcs_pkg::EXCESS_LIMIT;
			// once per frame, on first late hit
			inc[tcs_pkg::TCS_LATE] = tx_collision && slot_over && in_frame_q && !late_seen_q;
			// every collision, clear or secured traffic alike
			inc[tcs_pkg::TCS_TOTAL] = tx_collision;
		end
		if (tx_enabled_q) begin
			// rise of the combined defer condition, in either duplex
			inc[tcs_pkg::TCS_DEFER] = defer_now && !defer_prev_q;
			// carrier missing inside the first slot flags a link fault
			inc[tcs_pkg::TCS_NOCRS] = tx_success && !crs_seen_q && !(crs && !slot_over);
		end
	end

	// the counters; wrap on overflow is free from the adder
	// an event and its increment share one edge, so a read sees everything
	// up to the edge before its answer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < tcs_pkg::NUM_CNT; i++) begin
				cnt_q[i] <= tcs_pkg::CNT_RESET;
			end
		end else begin
			for (int i = 0; i < tcs_pkg::NUM_CNT; i++) begin
				if (inc[i]) begin
					cnt_q[i] <= cnt_q[i] + 32'h0000_0001;
				end
			end
		end
	end

	// retry threshold; only byte lane 0 carries it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			thresh_q <= tcs_pkg::THRESH_RESET;
		end else if (ctrl_wr && pstrb[0]) begin
			thresh_q <= pwdata[tcs_pkg::CTRL_THRESH_LSB +: 8];
		end
	end

	// transmit enable gates every counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_enabled_q <= 1'b0;
		end else if (ctrl_wr && pstrb[1]) begin
			tx_enabled_q <= pwdata[tcs_pkg::CTRL_TX_EN_BIT];
		end
	end

	// half duplex gates the collision counters only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			half_duplex_q <= 1'b0;
		end else if (ctrl_wr && pstrb[1]) begin
			half_duplex_q <= pwdata[tcs_pkg::CTRL_HALF_DUPLEX_BIT];
		end
	end

	// ready one cycle after the access edge; one wait state keeps every answer in a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= access && !pready;
		end
	end

	// error with ready for an unmapped index or any write to a read-only counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else if (access && !pready) begin
			if (!mapped) begin
				pslverr <= 1'b1; // unmapped
			end else if (pwrite && idx != tcs_pkg::IDX_CTRL) begin
				pslverr <= 1'b1; // counters are read-only
			end else begin
				pslverr <= 1'b0;
			end
		end else begin
			pslverr <= 1'b0;
		end
	end

	// read data stands only in the answer cycle; halves are not latched together,
	// so a counter that moves between the two reads can tear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (access && !pready) begin
			prdata <= read_word(idx);
		end else begin
			prdata <= 32'h0000_0000;
		end
	end

	// clear and secured traffic count alike, so the secure flag is not needed
	logic unused_ok;
	assign unused_ok = &{1'b0, tx_secure, paddr[11:10], paddr[1:0], pwdata[31:16], pstrb[3:2]};
endmodule
`default_nettype wire

/* tb/tcs_counters_props.sv */
/* tcs_counters_props: port checks of the statistics block's register access.
   Assumes one pclk domain and an async active-low presetn. */
`timescale 1ns/1ps
`default_nettype none
module tcs_counters_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// access phase taken by the slave
	wire logic tk = psel && penable && !pready;
	AST_RDY_NEXT: assert property (tk |=> pready) else $error("pready late");
	AST_RDY_PULSE: assert property (pready |=> !pready) else $error("pready held");
	AST_RDY_CAUSE: assert property (pready |-> $past(tk)) else $error("pready unasked");
	AST_ERR_PAIR: assert property (pslverr |-> pready) else $error("pslverr alone");
	AST_DATA_IDLE: assert property (!pready |-> prdata == 32'h0) else $error("prdata not idle");
	AST_HALF_W: assert property (pready |-> prdata[31:16] == 16'h0) else $error("half too wide");
	AST_RO_WR: assert property (tk && pwrite && paddr[9:2] != tcs_pkg::IDX_CTRL |=> pslverr)
		else $error("counter write taken");
	AST_RD_OK: assert property (tk && !pwrite && paddr[9:2] == tcs_pkg::IDX_SINGLE_COL |=> pready && !pslverr)
		else $error("counter read refused");
endmodule
bind tcs_counters tcs_counters_chk i_tcs_counters_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire

/* tb/tcs_mac_model.sv */
/* tcs_mac_model: transmitting LAN controller side, frames with retries and defers.
   Assumes tasks are called from one process; drives right after rising pclk. */
`timescale 1ns/1ps
`default_nettype none
module tcs_mac_model (
	input wire logic pclk,
	output logic tx_en,
	output logic crs,
	output logic tx_collision,
	output logic tx_success,
	output logic tx_secure,
	output logic [4:0] dfr,
	output logic tx_streaming
);
	initial {tx_en, crs, tx_collision, tx_success, tx_secure, dfr, tx_streaming} = '0;
	// n collided attempts, then success; stop at 16 so no stray attempt reopens a frame
	task automatic frame(input int n, input int gap, input logic car);
		for (int i = 0; i <= n && i < 16; i++) begin
			@(posedge pclk) begin tx_en <= 1'b1; crs <= car; tx_secure <= i[0]; end
			repeat (gap) @(posedge pclk);
			@(posedge pclk) begin tx_collision <= i < n; tx_success <= i == n; end
			@(posedge pclk) {tx_en, crs, tx_collision, tx_success} <= '0;
		end
	endtask
	// the defer causes in c for three cycles; idle cycle after gives a fresh rise
	task automatic defer(input logic [4:0] c, input logic s);
		@(posedge pclk) begin dfr <= c; tx_streaming <= s; end
		repeat (2) @(posedge pclk);
		@(posedge pclk) begin dfr <= '0; tx_streaming <= 1'b0; end
	endtask
endmodule
`default_nettype wire

/* tb/tcs_counters_test.sv */
/* tcs_counters_test: APB reads of all counters after frame and defer traffic.
   Assumes tcs_mac_model on the MAC side and a slot time shortened to 8 cycles. */
`timescale 1ns/1ps
`default_nettype none
module tcs_counters_test;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic tx_en, crs, tx_col, tx_ok, tx_sec, tx_str;
	logic [4:0] dfr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [31:0] exp_q [7];
	logic [7:0] idx [7] = '{8'h10, 8'h12, 8'h14, 8'h17, 8'h19, 8'h1b, 8'h1d};
	int errors = 0;
	int comparisons = 0;
	tcs_counters #(.SLOT_CYCLES(8)) i_tcs_counters (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .tx_en(tx_en), .crs(crs), .tx_collision(tx_col), .tx_success(tx_ok), .tx_secure(tx_sec),
		.defer_busy(dfr[0]), .defer_ipg(dfr[1]), .defer_hdx(dfr[2]), .defer_xoff(dfr[3]),
		.defer_link_down(dfr[4]), .tx_streaming(tx_str));
	tcs_mac_model i_tcs_mac_model (.pclk(pclk), .tx_en(tx_en), .crs(crs), .tx_collision(tx_col),
		.tx_success(tx_ok), .tx_secure(tx_sec), .dfr(dfr), .tx_streaming(tx_str));
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		comparisons++;
		if (s !== x) begin
			errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, s, x);
		end
	endtask
	// one APB transfer; hold everything until pready is seen
	task automatic apb(input logic [7:0] ix, input logic w, input logic [31:0] d);
		@(posedge pclk) begin psel <= 1'b1; pwrite <= w; paddr <= {2'h0, ix, 2'h0}; pwdata <= d; end
		@(posedge pclk) penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// lower index gives the high half
	task automatic check_all();
		logic [15:0] hi;
		for (int k = 0; k < 7; k++) begin
			apb(idx[k], 1'b0, 32'h0);
			hi = q[15:0];
			apb(idx[k] + 8'h1, 1'b0, 32'h0);
			chk({hi, q[15:0]}, exp_q[k]);
		end
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	// whole run needs about 600 cycles
	initial begin
		repeat (20000) @(posedge pclk);
		errors++;
		report_and_stop();
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		exp_q = '{default: 32'h0};
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		check_all();
		apb(8'h10, 1'b1, 32'hffff_ffff);
		chk({31'h0, e}, 32'h1);
		apb(8'h16, 1'b0, 32'h0);
		chk({31'h0, e}, 32'h1);
		apb(8'h20, 1'b1, 32'h310);
		i_tcs_mac_model.frame(1, 1, 1'b1);
		i_tcs_mac_model.frame(3, 1, 1'b1);
		i_tcs_mac_model.frame(2, 10, 1'b1);
		i_tcs_mac_model.frame(16, 1, 1'b1);
		i_tcs_mac_model.frame(0, 1, 1'b0);
		for (int c = 0; c < 5; c++) i_tcs_mac_model.defer(5'h1 << c, 1'b0);
		i_tcs_mac_model.defer(5'h02, 1'b1);
		i_tcs_mac_model.defer(5'h03, 1'b1);
		exp_q = '{32'h1, 32'h1, 32'h2, 32'h1, 32'h16, 32'h6, 32'h1};
		check_all();
		apb(8'h20, 1'b1, 32'h110);
		i_tcs_mac_model.frame(1, 1, 1'b1);
		i_tcs_mac_model.frame(3, 10, 1'b1);
		i_tcs_mac_model.defer(5'h01, 1'b0);
		exp_q[5] = 32'h7;
		check_all();
		apb(8'h20, 1'b1, 32'h30f);
		i_tcs_mac_model.frame(16, 1, 1'b1);
		exp_q[4] = 32'h26;
		check_all();
		apb(8'h20, 1'b1, 32'h20f);
		i_tcs_mac_model.defer(5'h01, 1'b0);
		i_tcs_mac_model.frame(0, 1, 1'b0);
		check_all();
		report_and_stop();
	end
endmodule
`default_nettype wire
